// ---- rtl/bcfl_div.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// enable divider: one tick every DIV enabled cycles
// ----------------------------------------------------------------
module bcfl_div #(
    parameter int DIV = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    output logic tick
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    localparam logic [W-1:0] ONE = W'(1);
    localparam logic [W-1:0] ZERO = W'(0);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // tick on the last enabled count
    assign tick = en && (cnt_q == LAST);

    // next count
    always_comb
    begin
        cnt_d = cnt_q;
        if (en)
            cnt_d = (cnt_q == LAST) ? ZERO : cnt_q + ONE;
    end

    // count register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= ZERO;
        else
            cnt_q <= cnt_d;
    end
endmodule

// ---- rtl/bcfl_top.sv ----
`timescale 1ns/1ns
// How it works
// - mode select high runs peak current chopping
// - five oscillator cycles, last two fast decay
// - oscillator is master/20, chop is master/100
// - charge until current reaches setting point
// - forced charge pulse at each period start
// - thermal latch cleared by standby toggle, cool
// - toggle while still hot keeps thermal latch
// - thermal detect off while standby low
// - any of eight overcurrents stops all
// - overcurrent ignored for first microsecond
// - overcurrent latch cleared by toggle or lockout
// - overcurrent detect off while standby low
// - protection flag low on thermal or overcurrent
// - supply flag low during supply lockout
// - supply low engages lockout, outputs off
// - supply recovered releases lockout
// - threshold is one third reference over sense
// - mode select low gives direct pwm
// - a low b high drives b to a
// - standby low puts outputs high impedance
module bcfl_top
    import bcfl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic STANDBY_N,
    input wire logic DIR_INPUT_A,
    input wire logic DIR_INPUT_B,
    input wire logic PWM_IN,
    input wire logic MODE_SEL,
    input wire logic CURRENT_PEAK,
    input wire logic [7:0] OC_DETECT,
    input wire logic OVER_TEMP,
    input wire logic BELOW_RECOVERY,
    input wire logic SUPPLY_LOW,
    input wire logic SUPPLY_OK,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic BRIDGE_OUT_A,
    output logic BRIDGE_OUT_A_OE_N,
    output logic BRIDGE_OUT_B,
    output logic BRIDGE_OUT_B_OE_N,
    input wire logic PROT_FAULT_FLAG_I,
    output logic PROT_FAULT_FLAG_O,
    output logic PROT_FAULT_FLAG_OE_N,
    input wire logic SUPPLY_FAULT_FLAG_I,
    output logic SUPPLY_FAULT_FLAG_O,
    output logic SUPPLY_FAULT_FLAG_OE_N
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic mclk_tick;
    logic osc_tick;
    bcfl_chop_t chop_q;
    bcfl_chop_t chop_d;
    logic [2:0] osc_q;
    logic [2:0] osc_d;
    logic [2:0] pulse_q;
    logic [2:0] pulse_d;
    logic therm_q;
    logic therm_d;
    logic oc_q;
    logic oc_d;
    logic [7:0] oc_src_q;
    logic [7:0] oc_src_d;
    logic [4:0] oc_cnt_q;
    logic [4:0] oc_cnt_d;
    logic lock_q;
    logic lock_d;
    logic sb_prev_q;
    logic oc_any;
    logic oc_trip;
    logic sb_rise;
    logic run;
    logic out_a_d;
    logic out_b_d;
    logic oe_n_d;
    logic out_a_q;
    logic out_b_q;
    logic oe_n_q;
    logic prot_oe_n_q;
    logic supply_oe_n_q;
    logic stop_q;
    logic stop_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic err_q;
    logic err_d;
    logic [31:0] status_w;
    bcfl_reg_t sel;

    // ----------------------------------------------------------------
    // master clock and chop oscillator enables
    // ----------------------------------------------------------------
    bcfl_div #(.DIV(MCLK_DIV)) u_mclk_div (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .en(1'b1),
        .tick(mclk_tick)
    );

    // oscillator runs at master/20, so the period is master/100
    bcfl_div #(.DIV(OSC_DIV)) u_osc_div (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .en(mclk_tick),
        .tick(osc_tick)
    );

    // ----------------------------------------------------------------
    // chopping phase sequencer
    // ----------------------------------------------------------------
    // next phase: charge, slow decay after peak, fixed fast decay tail
    always_comb
    begin
        chop_d = chop_q;
        osc_d = osc_q;
        pulse_d = pulse_q;
        if (pulse_q != 3'h0)
            pulse_d = pulse_q - 3'h1;
        if (osc_tick)
        begin
            if (osc_q == OSC_LAST)
            begin
                osc_d = 3'h0;
                chop_d = BCFL_CHARGE;
                pulse_d = PULSE_LAST;
            end
            else
            begin
                osc_d = osc_q + 3'h1;
                if (osc_q == OSC_PRE_FAST)
                    chop_d = BCFL_FAST;
            end
        end
        else if (chop_q == BCFL_CHARGE && pulse_q == 3'h0 && CURRENT_PEAK)
            chop_d = BCFL_SLOW;
    end

    // phase registers
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            chop_q <= BCFL_CHARGE;
            osc_q <= 3'h0;
            pulse_q <= 3'h0;
        end
        else
        begin
            chop_q <= chop_d;
            osc_q <= osc_d;
            pulse_q <= pulse_d;
        end
    end

    // ----------------------------------------------------------------
    // protection latches
    // ----------------------------------------------------------------
    assign oc_any = STANDBY_N && (|OC_DETECT);
    assign oc_trip = oc_any && (oc_cnt_q == OC_MASK_LAST);
    assign sb_rise = STANDBY_N && !sb_prev_q;

    // next latch state; a new detection wins over any clear
    always_comb
    begin
        therm_d = therm_q;
        oc_d = oc_q;
        oc_src_d = oc_src_q;
        oc_cnt_d = oc_any ? oc_cnt_q + 5'h1 : 5'h0;
        if (oc_trip)
            oc_cnt_d = oc_cnt_q;
        lock_d = lock_q;
        if (SUPPLY_LOW)
            lock_d = 1'b1;
        else if (SUPPLY_OK)
            lock_d = 1'b0;
        if (lock_q)
        begin
            therm_d = 1'b0;
            oc_d = 1'b0;
            oc_src_d = 8'h00;
        end
        if (sb_rise)
        begin
            if (BELOW_RECOVERY)
                therm_d = 1'b0;
            oc_d = 1'b0;
            oc_src_d = 8'h00;
        end
        if (STANDBY_N && OVER_TEMP)
            therm_d = 1'b1;
        if (oc_trip)
        begin
            oc_d = 1'b1;
            oc_src_d = oc_src_q | OC_DETECT;
        end
    end

    // latch registers
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            therm_q <= 1'b0;
            oc_q <= 1'b0;
            oc_src_q <= 8'h00;
            oc_cnt_q <= 5'h00;
            lock_q <= LOCK_RESET;
            sb_prev_q <= 1'b0;
        end
        else
        begin
            therm_q <= therm_d;
            oc_q <= oc_d;
            oc_src_q <= oc_src_d;
            oc_cnt_q <= oc_cnt_d;
            lock_q <= lock_d;
            sb_prev_q <= STANDBY_N;
        end
    end

    // ----------------------------------------------------------------
    // bridge drive
    // ----------------------------------------------------------------
    assign run = STANDBY_N && !therm_q && !oc_q && !lock_q && !stop_q;

    // output levels from direction, pwm, mode and chop phase
    always_comb
    begin
        out_a_d = 1'b0;
        out_b_d = 1'b0;
        oe_n_d = 1'b1;
        if (run && (DIR_INPUT_A || DIR_INPUT_B))
        begin
            oe_n_d = 1'b0;
            if (DIR_INPUT_A != DIR_INPUT_B && PWM_IN)
            begin
                if (!MODE_SEL)
                begin
                    out_a_d = DIR_INPUT_A;
                    out_b_d = DIR_INPUT_B;
                end
                else if (chop_q == BCFL_CHARGE)
                begin
                    out_a_d = DIR_INPUT_A;
                    out_b_d = DIR_INPUT_B;
                end
                else if (chop_q == BCFL_FAST)
                begin
                    out_a_d = DIR_INPUT_B;
                    out_b_d = DIR_INPUT_A;
                end
            end
        end
    end

    // output and flag registers
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
            oe_n_q <= 1'b1;
            prot_oe_n_q <= 1'b1;
            supply_oe_n_q <= 1'b1;
        end
        else
        begin
            out_a_q <= out_a_d;
            out_b_q <= out_b_d;
            oe_n_q <= oe_n_d;
            prot_oe_n_q <= !(therm_q || oc_q);
            supply_oe_n_q <= !lock_q;
        end
    end

    assign BRIDGE_OUT_A = out_a_q;
    assign BRIDGE_OUT_B = out_b_q;
    assign BRIDGE_OUT_A_OE_N = oe_n_q;
    assign BRIDGE_OUT_B_OE_N = oe_n_q;
    assign PROT_FAULT_FLAG_O = 1'b0;
    assign PROT_FAULT_FLAG_OE_N = prot_oe_n_q;
    assign SUPPLY_FAULT_FLAG_O = 1'b0;
    assign SUPPLY_FAULT_FLAG_OE_N = supply_oe_n_q;

    // ----------------------------------------------------------------
    // apb register slave
    // ----------------------------------------------------------------
    assign sel = bcfl_decode(PADDR);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && err_q;
    assign PRDATA = prdata_q;

    // status word and register access
    always_comb
    begin
        status_w = WORD_ZERO;
        status_w[ST_THERM_BIT] = therm_q;
        status_w[ST_OC_BIT] = oc_q;
        status_w[ST_LOCK_BIT] = lock_q;
        status_w[ST_CCMODE_BIT] = MODE_SEL;
        status_w[ST_PHASE_LSB +: 3] = osc_q;
        status_w[ST_CHOP_LSB +: 2] = chop_q;
        status_w[ST_PROT_PIN_BIT] = PROT_FAULT_FLAG_I;
        status_w[ST_SUPPLY_PIN_BIT] = SUPPLY_FAULT_FLAG_I;
        prdata_d = prdata_q;
        err_d = err_q;
        stop_d = stop_q;
        if (PSEL && !PENABLE)
        begin
            err_d = (sel == BCFL_REG_NONE);
            case (sel)
                BCFL_REG_CTRL: prdata_d = {31'h0000_0000, stop_q};
                BCFL_REG_STATUS: prdata_d = status_w;
                BCFL_REG_OCSRC: prdata_d = {24'h00_0000, oc_src_q};
                default: prdata_d = WORD_ZERO;
            endcase
        end
        if (PSEL && PENABLE && PWRITE && sel == BCFL_REG_CTRL)
            stop_d = PWDATA[CTRL_STOP_BIT];
    end

    // bus registers
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            prdata_q <= WORD_ZERO;
            err_q <= 1'b0;
            stop_q <= CTRL_RESET;
        end
        else
        begin
            prdata_q <= prdata_d;
            err_q <= err_d;
            stop_q <= stop_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    osc_spacing_a: assert property (osc_tick |-> ##100 osc_tick)
        else $error("chop oscillator tick spacing wrong");
    period_start_a: assert property ((osc_tick && osc_q == OSC_LAST)
        |=> (chop_q == BCFL_CHARGE && osc_q == 3'h0) [*5])
        else $error("charge pulse missing at period start");
    fast_decay_a: assert property ((osc_q > OSC_PRE_FAST) |-> chop_q == BCFL_FAST)
        else $error("fast decay not held to period end");
    peak_stop_a: assert property ((chop_q == BCFL_CHARGE && pulse_q == 3'h0
        && CURRENT_PEAK && !osc_tick) |=> chop_q == BCFL_SLOW)
        else $error("charge did not stop at setting point");
    thermal_hold_a: assert property ((therm_q && !BELOW_RECOVERY && !lock_q)
        |=> therm_q)
        else $error("thermal latch released while hot");
    thermal_off_a: assert property ((!STANDBY_N && !therm_q) |=> !therm_q)
        else $error("thermal detect active in standby");
    oc_mask_a: assert property ($rose(oc_q) |-> $past(oc_cnt_q) == OC_MASK_LAST
        && $past(oc_any, 20))
        else $error("overcurrent tripped inside mask");
    oc_latch_a: assert property ((oc_q && !lock_q && !(STANDBY_N && !sb_prev_q))
        |=> oc_q)
        else $error("overcurrent latch released itself");
    oc_off_a: assert property ((!STANDBY_N && !oc_q) |=> !oc_q)
        else $error("overcurrent detect active in standby");
    prot_flag_a: assert property ((therm_q || oc_q) |=> !PROT_FAULT_FLAG_OE_N
        && BRIDGE_OUT_A_OE_N && BRIDGE_OUT_B_OE_N)
        else $error("protection flag or shutdown missing");
    supply_flag_a: assert property (SUPPLY_LOW |=> ##1 (!SUPPLY_FAULT_FLAG_OE_N
        && BRIDGE_OUT_A_OE_N))
        else $error("supply lockout not shown");
    standby_hiz_a: assert property (!STANDBY_N |=> BRIDGE_OUT_A_OE_N
        && BRIDGE_OUT_B_OE_N)
        else $error("outputs driven in standby");
    brake_a: assert property ((run && DIR_INPUT_A != DIR_INPUT_B && !PWM_IN)
        |=> !BRIDGE_OUT_A_OE_N && !BRIDGE_OUT_A && !BRIDGE_OUT_B)
        else $error("pwm low did not short brake");

    thermal_release_c: cover property (therm_q ##1 !therm_q);
    oc_trip_c: cover property ($rose(oc_q));
    fast_decay_c: cover property (MODE_SEL && run && chop_q == BCFL_FAST);
    slow_decay_c: cover property (chop_q == BCFL_CHARGE ##1 chop_q == BCFL_SLOW);
endmodule

// ---- shared/bcfl_pkg.sv ----
// ----------------------------------------------------------------
// timing constants
// ----------------------------------------------------------------
package bcfl_pkg;
    localparam int CORE_PERIOD_NS = 50;
    localparam int MCLK_PERIOD_NS = 250; // 4 MHz master clock
    localparam int MCLK_DIV = MCLK_PERIOD_NS / CORE_PERIOD_NS;
    localparam int OSC_DIV = 20; // master clock ticks per chop oscillator cycle
    localparam logic [2:0] OSC_LAST = 3'h4; // five oscillator cycles per chop period
    localparam logic [2:0] OSC_PRE_FAST = 3'h2; // fast decay fills cycles 3 and 4
    localparam int OC_MASK_NS = 1000;
    localparam int OC_MASK_CYC = (OC_MASK_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam logic [4:0] OC_MASK_LAST = 5'(OC_MASK_CYC - 1);
    localparam int PULSE_NS = 250; // forced charge pulse, one master clock period
    localparam int PULSE_CYC = (PULSE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam logic [2:0] PULSE_LAST = 3'(PULSE_CYC - 1);

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] OCSRC_ADDR = 12'h008;
    localparam int CTRL_STOP_BIT = 0;
    localparam logic CTRL_RESET = 1'b0;
    localparam int ST_THERM_BIT = 0;
    localparam int ST_OC_BIT = 1;
    localparam int ST_LOCK_BIT = 2;
    localparam int ST_CCMODE_BIT = 3;
    localparam int ST_PHASE_LSB = 4; // three bits of oscillator count
    localparam int ST_CHOP_LSB = 7; // two bits of chop state
    localparam int ST_PROT_PIN_BIT = 9;
    localparam int ST_SUPPLY_PIN_BIT = 10;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic LOCK_RESET = 1'b1; // power-up counts as supply lockout

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BCFL_CHARGE = 2'b00,
        BCFL_SLOW = 2'b01,
        BCFL_FAST = 2'b11
    } bcfl_chop_t;

    typedef enum logic [1:0] {
        BCFL_REG_NONE,
        BCFL_REG_CTRL,
        BCFL_REG_STATUS,
        BCFL_REG_OCSRC
    } bcfl_reg_t;

    // address to register selector
    function automatic bcfl_reg_t bcfl_decode(input logic [11:0] addr);
        bcfl_reg_t r;
        r = BCFL_REG_NONE;
        if (addr == CTRL_ADDR)
            r = BCFL_REG_CTRL;
        else if (addr == STATUS_ADDR)
            r = BCFL_REG_STATUS;
        else if (addr == OCSRC_ADDR)
            r = BCFL_REG_OCSRC;
        return r;
    endfunction
endpackage

// ---- sim/bcfl_host.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// host controller model: standby, direction, pwm and mode pins
// ----------------------------------------------------------------
module bcfl_host (
    input wire logic clk,
    output logic standby_n,
    output logic dir_a,
    output logic dir_b,
    output logic pwm,
    output logic mode_sel
);
    // pins come up in standby, bridge stopped
    initial
    begin
        standby_n = 1'b0;
        dir_a = 1'b0;
        dir_b = 1'b0;
        pwm = 1'b0;
        mode_sel = 1'b0;
    end

    // set every control pin, called right after a rising edge
    task drive(input logic sb, input logic a, input logic b, input logic p, input logic m);
        standby_n <= sb;
        dir_a <= a;
        dir_b <= b;
        pwm <= p;
        mode_sel <= m;
    endtask

    // standby high-low-high to release latched faults
    task toggle();
        standby_n <= 1'b0;
        repeat (3) @(posedge clk);
        standby_n <= 1'b1;
    endtask

    // pwm half periods of 5 us: 100 kHz at 50% duty
    task burst(input int n);
        repeat (n)
        begin
            repeat (100) @(posedge clk);
            pwm <= ~pwm;
        end
    endtask
endmodule

// ---- sim/bridge_chopper_fault_latch_tb_top.sv ----
`timescale 1ns/1ns
module bridge_chopper_fault_latch_tb_top import bcfl_pkg::*;;
    logic clk = 1'b0;
    logic rst_n, peak, hot, cool, sup_low, sup_ok, psel, pen, pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] oc;
    logic pready, pslverr, oa, oa_oe_n, ob, ob_oe_n, pf_o, pf_oe_n, sf_o, sf_oe_n, e;
    logic sb_n, dir_a, dir_b, pwm, mode;
    logic [6:0] dtab [8];
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int nc, nf;
    wire pf_pin = pf_oe_n ? 1'b1 : pf_o; // pulled-up open drain
    wire sf_pin = sf_oe_n ? 1'b1 : sf_o;

    always #25 clk = ~clk;

    bcfl_host bcfl_host_i (.clk(clk), .standby_n(sb_n), .dir_a(dir_a), .dir_b(dir_b),
        .pwm(pwm), .mode_sel(mode));

    bcfl_top bcfl_top_i (.CORE_CLK(clk), .RESETN(rst_n), .STANDBY_N(sb_n),
        .DIR_INPUT_A(dir_a), .DIR_INPUT_B(dir_b), .PWM_IN(pwm), .MODE_SEL(mode),
        .CURRENT_PEAK(peak), .OC_DETECT(oc), .OVER_TEMP(hot), .BELOW_RECOVERY(cool),
        .SUPPLY_LOW(sup_low), .SUPPLY_OK(sup_ok), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BRIDGE_OUT_A(oa), .BRIDGE_OUT_A_OE_N(oa_oe_n),
        .BRIDGE_OUT_B(ob), .BRIDGE_OUT_B_OE_N(ob_oe_n), .PROT_FAULT_FLAG_I(pf_pin),
        .PROT_FAULT_FLAG_O(pf_o), .PROT_FAULT_FLAG_OE_N(pf_oe_n),
        .SUPPLY_FAULT_FLAG_I(sf_pin), .SUPPLY_FAULT_FLAG_O(sf_o),
        .SUPPLY_FAULT_FLAG_OE_N(sf_oe_n));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task wrap_up();
        $display("mismatches %0d of %0d compares", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task w(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer, held until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // count charge and fast decay cycles over two chop periods
    task count();
        nc = 0;
        nf = 0;
        repeat (1000)
        begin
            @(posedge clk);
            if (oa_oe_n === 1'b0 && {oa, ob} === 2'b01)
                nc++;
            if (oa_oe_n === 1'b0 && {oa, ob} === 2'b10)
                nf++;
        end
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        // {mode, a, b, pwm, oe_n, out_a, out_b}
        dtab = '{7'b0111000, 7'b0011001, 7'b0101010, 7'b0001100,
                 7'b0010000, 7'b1010000, 7'b1001100, 7'b1111000};
        rst_n = 1'b0;
        {peak, hot, cool, sup_low, sup_ok, psel, pen, pwr} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        oc = 8'h00;
        w(16);
        rst_n <= 1'b1;
        w(4);
        chk(sf_oe_n, 1'b0);
        chk(oa_oe_n, 1'b1);
        sup_ok <= 1'b1;
        cool <= 1'b1;
        w(4);
        chk(sf_oe_n, 1'b1);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(q & 32'h0000_0404, 32'h0000_0400);
        foreach (dtab[i])
        begin
            bcfl_host_i.drive(1'b1, dtab[i][5], dtab[i][4], dtab[i][3], dtab[i][6]);
            w(4);
            chk({oa_oe_n, ob_oe_n}, {2{dtab[i][2]}});
            if (dtab[i][2] == 1'b0)
                chk({oa, ob}, dtab[i][1:0]);
        end
        bcfl_host_i.drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        bcfl_host_i.burst(1);
        w(4);
        chk({oa_oe_n, oa, ob}, 3'b000);
        bcfl_host_i.drive(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        w(4);
        chk({oa_oe_n, ob_oe_n}, 2'b11);
        bcfl_host_i.drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        peak <= 1'b1;
        w(600);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(q[ST_CCMODE_BIT], 1'b1);
        count();
        chk(nc, 10);
        chk(nf, 400);
        peak <= 1'b0;
        w(600);
        count();
        chk(nc, 600);
        chk(nf, 400);
        bcfl_host_i.drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        cool <= 1'b0;
        hot <= 1'b1;
        w(3);
        hot <= 1'b0;
        w(4);
        chk(pf_oe_n, 1'b0);
        chk(oa_oe_n, 1'b1);
        bcfl_host_i.toggle();
        w(4);
        chk(pf_oe_n, 1'b0);
        cool <= 1'b1;
        w(1);
        bcfl_host_i.toggle();
        w(4);
        chk({pf_oe_n, oa_oe_n}, 2'b10);
        bcfl_host_i.drive(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        hot <= 1'b1;
        oc <= 8'hFF;
        w(30);
        hot <= 1'b0;
        oc <= 8'h00;
        w(2);
        bcfl_host_i.drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        w(4);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(q & 32'h3, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            oc <= 8'(8'h01 << i);
            w(19);
            oc <= 8'h00;
            w(4);
            chk(pf_oe_n, 1'b1);
            oc <= 8'(8'h01 << i);
            w(25);
            oc <= 8'h00;
            w(4);
            chk({pf_oe_n, oa_oe_n}, 2'b01);
            apb(1'b0, OCSRC_ADDR, 32'h0);
            chk(q & 32'hFF, 32'(1 << i));
            bcfl_host_i.toggle();
            w(4);
            chk({pf_oe_n, oa_oe_n}, 2'b10);
        end
        oc <= 8'h3C;
        w(25);
        oc <= 8'h00;
        sup_low <= 1'b1;
        w(4);
        chk({sf_oe_n, oa_oe_n, sf_o, pf_o}, 4'b0100);
        sup_low <= 1'b0;
        w(4);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(q & 32'h0000_0606, 32'h0000_0600);
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        w(4);
        chk(oa_oe_n, 1'b1);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(q, 32'h0000_0001);
        chk(e, 1'b0);
        apb(1'b1, CTRL_ADDR, 32'h0000_0000);
        apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, 12'h00C, 32'h0);
        chk(q, 32'h0000_0000);
        chk(e, 1'b1);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk({e, q[2:0]}, 4'h0);
        w(4);
        chk(oa_oe_n, 1'b0);
        wrap_up();
    end
endmodule
